// ===== rst_pwr_pkg.sv
// shared constants and types for the reset and sleep power controller
// Operation
// - io ports reset as soon as source active
// - registers held in reset, restart at vector
// - reset stretched by delay counter after sources
// - stretch length from startup and clock fuses
// - watchdog reset: expired, enabled, interrupt disabled
// - drop reset only while detector enabled
// - supply rise starts delay counter
// - supply fall reasserts reset without delay
// - long pin low pulse resets, short ignored
// - pin release starts delay counter
// - level fuse: 111 off, 110/101/100 levels
// - drop asserts at once, recovery starts counter
// - drops shorter than minimum width ignored
// - drop detector stays on in sleep
// - watchdog keeps running in sleep
// - comparator off in sleep except idle
// - reference kept on when comparator uses it
// - reference enabled only on demand
// - input buffers gated when io clock stops
// - software disables single input buffers
// - watchdog reset is one cycle pulse
// - sticky source flags, rise clears others
`default_nettype none
package rst_pwr_pkg;
	localparam int unsigned CLK_MHZ         = 125;
	localparam int unsigned DROP_MIN_NS     = 2;
	localparam int unsigned DROP_MIN_RAW    = (DROP_MIN_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned DROP_MIN_CYC    = (DROP_MIN_RAW < 1) ? 1 : DROP_MIN_RAW;
	localparam int unsigned CNT_W           = 16;
	localparam int unsigned ADDR_W          = 8;
	localparam logic [7:0]  ADDR_FLAGS      = 8'h00;
	localparam logic [7:0]  ADDR_IN_DIS     = 8'h04;
	localparam logic [7:0]  ADDR_STATUS     = 8'h08;
	localparam logic [1:0]  RESP_OKAY       = 2'h0;
	localparam logic [1:0]  RESP_SLVERR     = 2'h2;
	localparam int unsigned FLAG_W          = 4;
	localparam int unsigned FLAG_RISE       = 0;
	localparam int unsigned FLAG_PIN        = 1;
	localparam int unsigned FLAG_DROP       = 2;
	localparam int unsigned FLAG_WDOG       = 3;
	localparam logic [3:0]  FLAGS_POR       = 4'h1;
	localparam logic [2:0]  LVL_OFF         = 3'h7;
	localparam logic [2:0]  LVL_1V8         = 3'h6;
	localparam logic [2:0]  LVL_2V7         = 3'h5;
	localparam logic [2:0]  LVL_4V3         = 3'h4;
	localparam int unsigned ST_BIT_RESET    = 0;
	localparam int unsigned ST_BIT_STRETCH  = 1;
	localparam int unsigned ST_BIT_REF      = 2;
	localparam int unsigned ST_BIT_COMP     = 3;
	localparam int unsigned ST_BIT_DROP     = 4;
	localparam int unsigned ST_BIT_LVL      = 8;

	typedef enum logic [1:0] {SL_IDLE, SL_PDOWN, SL_STANDBY, SL_PDOWN_ALT} sleep_e;
	typedef enum logic [1:0] {ST_HOLD, ST_STRETCH, ST_RUN} seq_e;

	typedef struct packed {
		logic [2:0] drop_trigger_level_fuse;
		logic [1:0] startup_time_fuse;
		logic [3:0] clock_source_fuse;
	} fuse_s;

	typedef struct packed {
		logic       ref_en;
		logic       comp_en;
		logic       drop_en;
		logic       wdog_run;
		logic [2:0] drop_level;
	} power_s;
endpackage
`default_nettype wire

// ===== min_width_filter.sv
// passes a high level only once it has stood for a minimum number of cycles; a low level passes on the next cycle
`timescale 1ns/10ps
`default_nettype none
module min_width_filter #(
	parameter int unsigned WIDTH = 1
) (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic raw,
	output var  logic filt
);
	localparam int unsigned CW = $clog2(WIDTH + 1);
	localparam logic [CW-1:0] LAST = CW'(WIDTH - 1);

	logic [CW-1:0] cnt_q;
	wire long_enough = (cnt_q >= LAST);

	// saturating run length of the raw level
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			cnt_q <= '0;
		else if (!raw)
			cnt_q <= '0;
		else if (!long_enough)
			cnt_q <= cnt_q + CW'(1);
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			filt <= 1'b0;
		else
			filt <= raw && long_enough;
	end
endmodule // min_width_filter
`default_nettype wire

// ===== stretch_counter.sv
// delay counter that stretches reset after all sources let go
`timescale 1ns/10ps
`default_nettype none
module stretch_counter #(
	parameter int unsigned W = 16
) (
	input  wire logic         aclk,
	input  wire logic         aresetn,
	input  wire logic         hold,
	input  wire logic [W-1:0] len,
	output var  logic         busy
);
	logic [W-1:0] cnt_q;

	// reloads while any source holds, so a late source restarts the full time
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			cnt_q <= '1;
		else if (hold)
			cnt_q <= len;
		else if (cnt_q != '0)
			cnt_q <= cnt_q - W'(1);
	end

	assign busy = hold || (cnt_q != '0);
endmodule // stretch_counter
`default_nettype wire

// ===== reset_power_ctrl.sv
// reset source combiner, reset stretcher, sleep power gating and axi4-lite registers
//
// Decided for this implementation: the AXI4-Lite register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module reset_power_ctrl #(
	parameter int unsigned N_PINS        = 8,
	parameter int unsigned PIN_MIN_NS    = 2000,
	parameter int unsigned STRETCH_BASE  = 16
) (
	input  wire logic                      aclk,
	input  wire logic                      aresetn,
	input  wire logic [7:0]                awaddr,
	input  wire logic                      awvalid,
	output var  logic                      awready,
	input  wire logic [31:0]               wdata,
	input  wire logic [3:0]                wstrb,
	input  wire logic                      wvalid,
	output var  logic                      wready,
	output var  logic [1:0]                bresp,
	output var  logic                      bvalid,
	input  wire logic                      bready,
	input  wire logic [7:0]                araddr,
	input  wire logic                      arvalid,
	output var  logic                      arready,
	output var  logic [31:0]               rdata,
	output var  logic [1:0]                rresp,
	output var  logic                      rvalid,
	input  wire logic                      rready,
	input  wire rst_pwr_pkg::fuse_s        fuses,
	input  wire logic                      supply_above_rise,
	input  wire logic                      reset_pin_n,
	input  wire logic                      supply_below_drop,
	input  wire logic                      wdog_expire,
	input  wire logic                      wdog_enable,
	input  wire logic                      wdog_int_enable,
	input  wire logic                      sleep_active,
	input  wire rst_pwr_pkg::sleep_e       sleep_mode,
	input  wire logic                      comp_on_sw,
	input  wire logic                      comp_uses_ref,
	input  wire logic [N_PINS-1:0]         wake_pin_mask,
	output var  logic                      io_reset_q,
	output var  logic                      core_reset_q,
	output var  logic                      vector_start_q,
	output var  rst_pwr_pkg::power_s       power_q,
	output var  logic [N_PINS-1:0]         in_buf_en_q
);
	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int unsigned PIN_MIN_RAW = (PIN_MIN_NS * rst_pwr_pkg::CLK_MHZ + 999) / 1000;
	localparam int unsigned PIN_MIN_CYC = (PIN_MIN_RAW < 1) ? 1 : PIN_MIN_RAW;
	localparam int unsigned CW = rst_pwr_pkg::CNT_W;

	// ------------------------------------------------------------
	// reset sources
	// ------------------------------------------------------------
	logic drop_on;
	logic rise_src;
	logic pin_src;
	logic drop_src;
	logic wd_fire;
	logic wd_fire_q;
	logic wdog_pulse_q;
	logic src_active;
	logic stretch_busy;
	logic [CW-1:0] stretch_len;
	logic [2:0] len_shift;

	// reserved level codes are treated like the disabled code
	assign drop_on = (fuses.drop_trigger_level_fuse == rst_pwr_pkg::LVL_1V8)
		|| (fuses.drop_trigger_level_fuse == rst_pwr_pkg::LVL_2V7)
		|| (fuses.drop_trigger_level_fuse == rst_pwr_pkg::LVL_4V3);

	// supply fall bypasses any filter so reset comes back at once
	assign rise_src = !supply_above_rise;

	min_width_filter #(.WIDTH(PIN_MIN_CYC)) u_pin_filter (
		.aclk    (aclk),
		.aresetn (aresetn),
		.raw     (!reset_pin_n),
		.filt    (pin_src)
	);

	min_width_filter #(.WIDTH(rst_pwr_pkg::DROP_MIN_CYC)) u_drop_filter (
		.aclk    (aclk),
		.aresetn (aresetn),
		.raw     (supply_below_drop && drop_on),
		.filt    (drop_src)
	);

	assign wd_fire = wdog_expire && wdog_enable && !wdog_int_enable;

	// a held expiry still yields a single pulse
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			wd_fire_q <= 1'b0;
			wdog_pulse_q <= 1'b0;
		end
		else
		begin
			wd_fire_q <= wd_fire;
			wdog_pulse_q <= wd_fire && !wd_fire_q;
		end
	end

	assign src_active = rise_src || pin_src || drop_src || wdog_pulse_q;

	// ------------------------------------------------------------
	// reset stretch
	// ------------------------------------------------------------
	assign len_shift = {fuses.startup_time_fuse, fuses.clock_source_fuse[0]};
	assign stretch_len = CW'(STRETCH_BASE) << len_shift;

	stretch_counter #(.W(CW)) u_stretch (
		.aclk    (aclk),
		.aresetn (aresetn),
		.hold    (src_active),
		.len     (stretch_len),
		.busy    (stretch_busy)
	);

	rst_pwr_pkg::seq_e seq_q;
	rst_pwr_pkg::seq_e seq_d;

	always_comb
	begin
		seq_d = seq_q;
		unique case (seq_q)
			rst_pwr_pkg::ST_HOLD:
				if (!src_active)
					seq_d = rst_pwr_pkg::ST_STRETCH;
			rst_pwr_pkg::ST_STRETCH:
				if (src_active)
					seq_d = rst_pwr_pkg::ST_HOLD;
				else if (!stretch_busy)
					seq_d = rst_pwr_pkg::ST_RUN;
			rst_pwr_pkg::ST_RUN:
				if (src_active)
					seq_d = rst_pwr_pkg::ST_HOLD;
			// the unused code falls back to holding reset
			default:
				seq_d = rst_pwr_pkg::ST_HOLD;
		endcase
	end

	wire core_reset_d = (seq_d != rst_pwr_pkg::ST_RUN);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			seq_q <= rst_pwr_pkg::ST_HOLD;
			core_reset_q <= 1'b1;
			io_reset_q <= 1'b1;
			vector_start_q <= 1'b0;
		end
		else
		begin
			seq_q <= seq_d;
			core_reset_q <= core_reset_d;
			io_reset_q <= src_active;
			vector_start_q <= core_reset_q && !core_reset_d;
		end
	end

	// ------------------------------------------------------------
	// sleep power gating
	// ------------------------------------------------------------
	wire deep_sleep = sleep_active && (sleep_mode != rst_pwr_pkg::SL_IDLE);
	rst_pwr_pkg::power_s power_d;
	logic [N_PINS-1:0] in_dis_q;
	logic [N_PINS-1:0] in_buf_en_d;

	assign power_d.drop_en = drop_on;
	assign power_d.wdog_run = wdog_enable;
	assign power_d.comp_en = comp_on_sw && !deep_sleep;
	assign power_d.ref_en = drop_on || comp_uses_ref;
	assign power_d.drop_level = fuses.drop_trigger_level_fuse;

	// wake pins keep their buffers through deep sleep
	genvar gi;
	generate
		for (gi = 0; gi < N_PINS; gi++)
		begin : g_buf
			assign in_buf_en_d[gi] = !in_dis_q[gi] && (!deep_sleep || wake_pin_mask[gi]);
		end
	endgenerate

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			power_q <= '0;
			in_buf_en_q <= '0;
		end
		else
		begin
			power_q <= power_d;
			in_buf_en_q <= in_buf_en_d;
		end
	end

	// ------------------------------------------------------------
	// axi4-lite write
	// ------------------------------------------------------------
	logic aw_hold_q;
	logic w_hold_q;
	logic [7:0] waddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic [rst_pwr_pkg::FLAG_W-1:0] flags_q;

	wire aw_take = awvalid && awready;
	wire w_take = wvalid && wready;
	wire do_write = aw_hold_q && w_hold_q && !bvalid;
	wire aw_hold_d = (aw_hold_q || aw_take) && !do_write;
	wire w_hold_d = (w_hold_q || w_take) && !do_write;
	wire wr_flags = do_write && (waddr_q == rst_pwr_pkg::ADDR_FLAGS) && wstrb_q[0];
	wire wr_in_dis = do_write && (waddr_q == rst_pwr_pkg::ADDR_IN_DIS) && wstrb_q[0];
	wire wr_known = (waddr_q == rst_pwr_pkg::ADDR_FLAGS) || (waddr_q == rst_pwr_pkg::ADDR_IN_DIS)
		|| (waddr_q == rst_pwr_pkg::ADDR_STATUS);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_hold_q <= 1'b0;
			w_hold_q <= 1'b0;
			awready <= 1'b1;
			wready <= 1'b1;
			bvalid <= 1'b0;
			bresp <= rst_pwr_pkg::RESP_OKAY;
			waddr_q <= '0;
			wdata_q <= '0;
			wstrb_q <= '0;
		end
		else
		begin
			aw_hold_q <= aw_hold_d;
			w_hold_q <= w_hold_d;
			awready <= !aw_hold_d;
			wready <= !w_hold_d;
			if (aw_take)
				waddr_q <= awaddr;
			if (w_take)
			begin
				wdata_q <= wdata;
				wstrb_q <= wstrb;
			end
			if (do_write)
			begin
				bvalid <= 1'b1;
				bresp <= wr_known ? rst_pwr_pkg::RESP_OKAY : rst_pwr_pkg::RESP_SLVERR;
			end
			else if (bready)
				bvalid <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// reset flags and input disable register
	// ------------------------------------------------------------
	wire [rst_pwr_pkg::FLAG_W-1:0] flag_set = {wdog_pulse_q, drop_src, pin_src, 1'b0};
	wire [rst_pwr_pkg::FLAG_W-1:0] flag_keep = wr_flags ? wdata_q[rst_pwr_pkg::FLAG_W-1:0] : '1;
	wire [rst_pwr_pkg::FLAG_W-1:0] flags_d = rise_src ? rst_pwr_pkg::FLAGS_POR
		: ((flags_q & flag_keep) | flag_set);

	// a source firing in the cycle of a clearing write keeps its flag
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			flags_q <= rst_pwr_pkg::FLAGS_POR;
			in_dis_q <= '0;
		end
		else
		begin
			flags_q <= flags_d;
			if (wr_in_dis)
				in_dis_q <= wdata_q[N_PINS-1:0];
		end
	end

	// ------------------------------------------------------------
	// axi4-lite read
	// ------------------------------------------------------------
	wire ar_take = arvalid && arready;
	wire rvalid_d = ar_take || (rvalid && !rready);
	logic [31:0] status_word;
	logic [31:0] rd_word;
	logic rd_known;

	assign status_word = (32'(core_reset_q) << rst_pwr_pkg::ST_BIT_RESET)
		| (32'(seq_q == rst_pwr_pkg::ST_STRETCH) << rst_pwr_pkg::ST_BIT_STRETCH)
		| (32'(power_q.ref_en) << rst_pwr_pkg::ST_BIT_REF)
		| (32'(power_q.comp_en) << rst_pwr_pkg::ST_BIT_COMP)
		| (32'(power_q.drop_en) << rst_pwr_pkg::ST_BIT_DROP)
		| (32'(power_q.drop_level) << rst_pwr_pkg::ST_BIT_LVL);

	assign rd_known = (araddr == rst_pwr_pkg::ADDR_FLAGS) || (araddr == rst_pwr_pkg::ADDR_IN_DIS)
		|| (araddr == rst_pwr_pkg::ADDR_STATUS);
	assign rd_word = (araddr == rst_pwr_pkg::ADDR_FLAGS) ? 32'(flags_q)
		: (araddr == rst_pwr_pkg::ADDR_IN_DIS) ? 32'(in_dis_q)
		: (araddr == rst_pwr_pkg::ADDR_STATUS) ? status_word : '0;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			arready <= 1'b1;
			rvalid <= 1'b0;
			rdata <= '0;
			rresp <= rst_pwr_pkg::RESP_OKAY;
		end
		else
		begin
			arready <= !rvalid_d;
			rvalid <= rvalid_d;
			if (ar_take)
			begin
				rdata <= rd_word;
				rresp <= rd_known ? rst_pwr_pkg::RESP_OKAY : rst_pwr_pkg::RESP_SLVERR;
			end
		end
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_sources_gone;
		$fell(src_active);
	endsequence

	sequence s_held_eight;
		core_reset_q [*8];
	endsequence

	sequence s_wdog_single;
		wdog_pulse_q ##1 !wdog_pulse_q;
	endsequence

	a_io_reset_follow: assert property (src_active |=> io_reset_q)
		else $error("io reset missed an active source");
	a_core_held_src: assert property (src_active |=> core_reset_q)
		else $error("core left reset while a source was active");
	a_stretch_min_hold: assert property (s_sources_gone |-> s_held_eight)
		else $error("reset released before stretch ran");
	a_vector_on_release: assert property ($fell(core_reset_q) |-> vector_start_q)
		else $error("no restart pulse on reset release");
	a_wdog_fires: assert property (wd_fire && !wd_fire_q |=> s_wdog_single)
		else $error("watchdog reset pulse wrong");
	a_wdog_masked: assert property (!wd_fire |=> !wdog_pulse_q)
		else $error("watchdog pulse without cause");
	a_drop_gated: assert property (!drop_on && $stable(drop_on) |=> !drop_src)
		else $error("drop reset while detector disabled");
	a_rise_at_once: assert property (!supply_above_rise |=> core_reset_q && io_reset_q)
		else $error("supply fall did not reset at once");
	a_comp_off_deep: assert property (deep_sleep |=> !power_q.comp_en)
		else $error("comparator on in deep sleep");
	a_ref_on_demand: assert property (1'b1 |=> power_q.ref_en == ($past(drop_on) || $past(comp_uses_ref)))
		else $error("reference enable mismatch");
	a_buffer_gate: assert property (deep_sleep && !wake_pin_mask[0] |=> !in_buf_en_q[0])
		else $error("input buffer left on in deep sleep");
	a_flags_rise_clear: assert property (rise_src |=> flags_q == rst_pwr_pkg::FLAGS_POR)
		else $error("supply rise did not clear other flags");
	a_restart_stretch: assert property (seq_q == rst_pwr_pkg::ST_STRETCH && src_active
		|=> seq_q == rst_pwr_pkg::ST_HOLD)
		else $error("stretch not restarted by new source");
	a_bvalid_stays: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped early");
endmodule // reset_power_ctrl
`default_nettype wire

// ===== placeholder_end.sv
// intentionally empty file kept for compile order
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// ===== reset_source_and_sleep_power_ctrl_tb.sv
// self-checking testbench for the reset source combiner and sleep power controller
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin error_cnt++; $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module reset_source_and_sleep_power_ctrl_tb;
	// ----------------------------------------
	// signals and device
	// ----------------------------------------
	localparam int unsigned BASE = 16;
	logic                  aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic                  arvalid, arready, rvalid, rready;
	logic [7:0]            awaddr, araddr, wake_pin_mask, in_buf_en_q;
	logic [31:0]           wdata, rdata;
	logic [3:0]            wstrb;
	logic [1:0]            bresp, rresp;
	rst_pwr_pkg::fuse_s    fuses;
	rst_pwr_pkg::sleep_e   sleep_mode;
	rst_pwr_pkg::power_s   power_q;
	logic                  supply_above_rise, reset_pin_n, supply_below_drop, wdog_expire, wdog_enable;
	logic                  wdog_int_enable, sleep_active, comp_on_sw, comp_uses_ref;
	logic                  io_reset_q, core_reset_q, vector_start_q;
	int                    error_cnt, num_checks, cur_len;

	reset_power_ctrl #(.N_PINS(8), .PIN_MIN_NS(16), .STRETCH_BASE(BASE)) dut_u (
		.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
		.rresp(rresp), .rvalid(rvalid), .rready(rready), .fuses(fuses), .supply_above_rise(supply_above_rise),
		.reset_pin_n(reset_pin_n), .supply_below_drop(supply_below_drop), .wdog_expire(wdog_expire),
		.wdog_enable(wdog_enable), .wdog_int_enable(wdog_int_enable), .sleep_active(sleep_active),
		.sleep_mode(sleep_mode), .comp_on_sw(comp_on_sw), .comp_uses_ref(comp_uses_ref),
		.wake_pin_mask(wake_pin_mask), .io_reset_q(io_reset_q), .core_reset_q(core_reset_q),
		.vector_start_q(vector_start_q), .power_q(power_q), .in_buf_en_q(in_buf_en_q));

	initial
	begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end

	// ----------------------------------------
	// bus and timing helpers
	// ----------------------------------------
	task automatic tick(input int n);
		repeat (n) @(posedge aclk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
		int n;
		n = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			n++;
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end
		while (bvalid !== 1'b1 && n < 100);
		resp = bresp;
		bready <= 1'b0;
		if (n >= 100) error_cnt++;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
		int n;
		n = 0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			n++;
			if (arready) arvalid <= 1'b0;
		end
		while (rvalid !== 1'b1 && n < 100);
		d = rdata;
		resp = rresp;
		rready <= 1'b0;
		if (n >= 100) error_cnt++;
	endtask

	task automatic chk_flags(input logic [3:0] exp);
		logic [31:0] d;
		logic [1:0]  r;
		rd(rst_pwr_pkg::ADDR_FLAGS, d, r);
		`CHK(d, {28'h0, exp})
	endtask

	task automatic see_reset(input int lim, input logic exp);
		logic seen;
		seen = 1'b0;
		repeat (lim)
		begin
			@(posedge aclk);
			if (core_reset_q === 1'b1) seen = 1'b1;
		end
		`CHK(seen, exp)
	endtask

	// counts edges until core reset drops; the start pulse must come with the fall
	task automatic stretch(input int lo, input int hi);
		int n;
		n = 0;
		do
		begin
			@(posedge aclk);
			n++;
		end
		while (core_reset_q === 1'b1 && n < 2000);
		`CHK(n >= lo && n <= hi, 1'b1)
		`CHK(vector_start_q, 1'b1)
		@(posedge aclk);
		`CHK(vector_start_q, 1'b0)
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_por(input logic [2:0] sel);
		fuses.startup_time_fuse <= sel[2:1];
		fuses.clock_source_fuse[0] <= sel[0];
		cur_len = BASE << sel;
		@(posedge aclk);
		supply_above_rise <= 1'b0;
		tick(2);
		`CHK(io_reset_q, 1'b1)
		`CHK(core_reset_q, 1'b1)
		tick(3);
		supply_above_rise <= 1'b1;
		stretch(cur_len, cur_len + 5);
		chk_flags(4'h1);
	endtask

	task automatic t_pin();
		logic [1:0] r;
		wr(rst_pwr_pkg::ADDR_FLAGS, 32'h0, r);
		chk_flags(4'h0);
		reset_pin_n <= 1'b0;
		@(posedge aclk);
		reset_pin_n <= 1'b1;
		see_reset(6, 1'b0);
		reset_pin_n <= 1'b0;
		tick(5);
		`CHK(io_reset_q, 1'b1)
		reset_pin_n <= 1'b1;
		tick(cur_len / 2);
		reset_pin_n <= 1'b0;
		tick(5);
		reset_pin_n <= 1'b1;
		stretch(cur_len, cur_len + 5);
		chk_flags(4'h2);
	endtask

	task automatic t_wdog();
		int n;
		wdog_enable <= 1'b1;
		wdog_int_enable <= 1'b1;
		wdog_expire <= 1'b1;
		@(posedge aclk);
		wdog_expire <= 1'b0;
		see_reset(8, 1'b0);
		wdog_int_enable <= 1'b0;
		wdog_expire <= 1'b1;
		@(posedge aclk);
		wdog_expire <= 1'b0;
		n = 0;
		repeat (6)
		begin
			@(posedge aclk);
			if (io_reset_q === 1'b1) n++;
		end
		`CHK(n == 1, 1'b1)
		stretch(cur_len - 6, cur_len);
		chk_flags(4'ha);
	endtask

	task automatic t_drop();
		logic [2:0] lv [5] = '{3'h7, 3'h3, 3'h6, 3'h5, 3'h4};
		logic       on;
		foreach (lv[i])
		begin
			on = lv[i][2] && lv[i] != rst_pwr_pkg::LVL_OFF;
			fuses.drop_trigger_level_fuse <= lv[i];
			tick(3);
			`CHK(power_q.drop_en, on)
			`CHK(power_q.ref_en, on)
			supply_below_drop <= 1'b1;
			see_reset(4, on);
			supply_below_drop <= 1'b0;
			if (on) stretch(cur_len, cur_len + 5);
		end
		chk_flags(4'he);
	endtask

	task automatic t_power();
		logic [1:0]  r;
		logic [31:0] d;
		wr(rst_pwr_pkg::ADDR_IN_DIS, 32'h0000_000f, r);
		`CHK(r, rst_pwr_pkg::RESP_OKAY)
		wr(8'h40, 32'h0, r);
		`CHK(r, rst_pwr_pkg::RESP_SLVERR)
		rd(8'h40, d, r);
		`CHK({r, d}, {rst_pwr_pkg::RESP_SLVERR, 32'h0})
		fuses.drop_trigger_level_fuse <= rst_pwr_pkg::LVL_OFF;
		wake_pin_mask <= 8'h30;
		wdog_enable <= 1'b1;
		comp_on_sw <= 1'b1;
		sleep_active <= 1'b1;
		for (int m = 0; m < 4; m++)
		begin
			sleep_mode <= rst_pwr_pkg::sleep_e'(m);
			comp_uses_ref <= m[0];
			tick(3);
			`CHK(power_q.comp_en, m == 0)
			`CHK(power_q.ref_en, m[0])
			`CHK(power_q.wdog_run, 1'b1)
			`CHK(in_buf_en_q, (m == 0) ? 8'hf0 : 8'h30)
		end
		fuses.drop_trigger_level_fuse <= rst_pwr_pkg::LVL_1V8;
		tick(3);
		`CHK(power_q.drop_en, 1'b1)
		sleep_active <= 1'b0;
		tick(3);
		`CHK(in_buf_en_q, 8'hf0)
		`CHK(power_q.drop_level, rst_pwr_pkg::LVL_1V8)
		rd(rst_pwr_pkg::ADDR_IN_DIS, d, r);
		`CHK({r, d}, {rst_pwr_pkg::RESP_OKAY, 32'h0000_000f})
		// running, reference, comparator and detector on, level 110 in bits 10:8
		rd(rst_pwr_pkg::ADDR_STATUS, d, r);
		`CHK({r, d}, {rst_pwr_pkg::RESP_OKAY, 32'h0000_061c})
	endtask

	task automatic finish_test();
		$display("checks=%0d errors=%0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// whole sequence needs a few thousand cycles; this cuts a hang short
	initial
	begin
		#200000;
		error_cnt++;
		finish_test();
	end

	initial
	begin
		error_cnt = 0;
		num_checks = 0;
		cur_len = BASE;
		aresetn = 1'b0;
		{awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
		wstrb = 4'h1;
		fuses = '0;
		fuses.drop_trigger_level_fuse = rst_pwr_pkg::LVL_OFF;
		{supply_below_drop, wdog_expire, wdog_enable, wdog_int_enable} = '0;
		{sleep_active, comp_on_sw, comp_uses_ref, wake_pin_mask} = '0;
		sleep_mode = rst_pwr_pkg::SL_IDLE;
		supply_above_rise = 1'b1;
		reset_pin_n = 1'b1;
		tick(16);
		aresetn <= 1'b1;
		t_por(3'h0);
		t_por(3'h5);
		t_pin();
		t_wdog();
		t_drop();
		t_por(3'h5);
		t_power();
		finish_test();
	end
endmodule // reset_source_and_sleep_power_ctrl_tb
`default_nettype wire
